/* File: logic/fsps_seq.sv */
// flash self-programming sequencer: command decode, page buffer, timing
`timescale 1ns/1ps
`include "fsps_regs.svh"
// Operation
// RL1: reset vector is zero when boot fuse is one, boot address when zero.
// RL2: fuses are inputs only; the processor has no path to change them.
// RL3: flash address is extension, high and low pointer bytes together.
// RL4: address is latched at operation start; pointer may change afterward.
// RL5: program reads are byte addressed, pointer bit zero picks the byte.
// RL6: software erases a page before writing buffered data into it.
// RL7: software gives the same page address to erase and write.
// RL8: code x0000011 then store within four cycles erases the pointed page.
// RL9: erase in halting region halts cpu; other region keeps halting readable.
// RL10: code 00000001 then store loads data pair into word slot.
// RL11: buffer slots may be written in any order.
// RL12: buffer clears after page write, on re-enable write, and at reset.
// RL13: software writes each slot at most once between buffer clears.
// RL14: an eeprom write during loading keeps the loaded buffer words.
// RL15: code x0000101 then store writes the buffer into the pointed page.
// RL16: write in halting region halts cpu; other region stays readable; the code still sets busy and region_blocked during this write.
// RL17: enabled interrupt is asserted steadily while the arm bit is clear.
// RL18: readable region blocked and busy flag set during erase and write.
// RL19: writing the re-enable bit clears the busy flag after completion.
// RL20: code x0001001 then store programs lock bits that are zero in data.
// RL21: pointer is ignored for lock writes; software hints are optional.
// RL22: whole flash stays readable and cpu runs during lock programming.
// RL23: lock bits are only programmed here; only chip erase clears them.
// RL24: each erase, write or lock operation lasts between 3.7 and 4.5 ms.
// RL25: no programming starts while an eeprom write is in progress.
// RL26: no store within the window clears arm and command bits.
// RL27: operation completion clears the arm bit.
module fsps_seq #(
  parameter int PROG_CYC = `FSPS_PROG_CYC,
  parameter logic [23:0] BOOT_RESET = 24'h03e000,
  parameter logic [23:0] HALT_BASE = 24'h03e000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic csr_we,
  input wire logic [7:0] csr_wdata,
  output logic [7:0] csr_rdata,
  input wire logic ext_we,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata,
  input wire logic store_exec,
  input wire fsps_pkg::fsps_ptr_t ptr,
  input wire fsps_pkg::fsps_data_t data_in,
  input wire logic [15:0] pointer_word,
  output logic [23:0] prog_byte_addr,
  input wire logic boot_reset_select,
  output logic [23:0] reset_vector,
  input wire logic eeprom_busy,
  output logic cpu_halt,
  output logic region_blocked,
  output logic selfprog_irq,
  output logic [7:0] lock_bits,
  output logic flash_prog_we,
  output logic [23:0] flash_page_addr,
  output logic [15:0] flash_wdata,
  output logic [6:0] flash_word_idx
);
  // ==========================================================
  // reset release
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_n = rst_s2_q;

  // ==========================================================
  // control register and command window
  logic [7:0] cmd_q;
  logic ien_q, busy_q;
  logic [2:0] win_q;
  logic [31:0] cnt_q;
  fsps_pkg::fsps_op_t op_q;
  logic [23:0] addr_q;
  logic [7:0] ext_q;
  logic [7:0] code;
  logic armed, fire, op_done, reen_wr;
  assign code = csr_wdata & `FSPS_CMD_MASK;
  assign armed = cmd_q[`FSPS_BIT_ARM];
  assign fire = armed && store_exec && op_q == fsps_pkg::FSPS_OP_NONE;
  assign op_done = op_q != fsps_pkg::FSPS_OP_NONE && cnt_q == 32'h1;
  // busy flag drop is only honoured once no operation runs
  assign reen_wr = csr_we && code == `FSPS_CMD_REEN && !eeprom_busy &&
                   op_q == fsps_pkg::FSPS_OP_NONE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= `FSPS_CSR_RST;
      win_q <= 3'h0;
    end else if (csr_we && !eeprom_busy &&
                 op_q == fsps_pkg::FSPS_OP_NONE) begin // RL25
      cmd_q <= code;
      win_q <= `FSPS_WINDOW;
    end else if (fire) begin
      win_q <= 3'h0;
      // codes that start no timed operation end with their store
      if (cmd_q != `FSPS_CMD_ERASE && cmd_q != `FSPS_CMD_PGWR &&
          cmd_q != `FSPS_CMD_LOCK)
        cmd_q <= 8'h00;
    end else if (op_done) begin
      cmd_q <= 8'h00; // RL27
    end else if (win_q == 3'h1 && op_q == fsps_pkg::FSPS_OP_NONE) begin
      cmd_q <= 8'h00; // RL26
      win_q <= 3'h0;
    end else if (win_q != 3'h0) begin
      win_q <= win_q - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ien_q <= 1'b0;
    else if (csr_we && !eeprom_busy && op_q == fsps_pkg::FSPS_OP_NONE)
      ien_q <= csr_wdata[`FSPS_BIT_IEN];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ext_q <= `FSPS_EXT_RST;
    else if (ext_we)
      ext_q <= ext_wdata;
  end
  assign ext_rdata = ext_q;

  // ==========================================================
  // operation timer
  logic start_er, start_wr, start_lk;
  assign start_er = fire && cmd_q == `FSPS_CMD_ERASE; // RL8
  assign start_wr = fire && cmd_q == `FSPS_CMD_PGWR; // RL15
  assign start_lk = fire && cmd_q == `FSPS_CMD_LOCK; // RL20

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= fsps_pkg::FSPS_OP_NONE;
      cnt_q <= 32'h0;
    end else if (start_er || start_wr || start_lk) begin
      op_q <= start_er ? fsps_pkg::FSPS_OP_ERASE :
              start_wr ? fsps_pkg::FSPS_OP_PGWR : fsps_pkg::FSPS_OP_LOCK;
      cnt_q <= 32'(PROG_CYC); // RL24
    end else if (op_done) begin
      op_q <= fsps_pkg::FSPS_OP_NONE;
      cnt_q <= 32'h0;
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  // word bits dropped: only the page index addresses erase and write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      addr_q <= 24'h0;
    else if (start_er || start_wr)
      addr_q <= {ext_q, ptr.high, ptr.low} &
                ~24'(2 * `FSPS_PAGE_WORDS - 1); // RL3 RL4
  end
  assign flash_page_addr = addr_q;

  // ==========================================================
  // busy flag and region blocking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy_q <= 1'b0;
    else if (start_er || start_wr)
      busy_q <= 1'b1; // RL18
    else if (reen_wr)
      busy_q <= 1'b0; // RL19
  end
  logic prog_run, in_halt;
  assign prog_run = op_q == fsps_pkg::FSPS_OP_ERASE ||
                    op_q == fsps_pkg::FSPS_OP_PGWR;
  assign in_halt = addr_q >= HALT_BASE;
  assign region_blocked = busy_q;
  // lock operations never halt the cpu
  assign cpu_halt = prog_run && in_halt; // RL9 RL16 RL22
  assign selfprog_irq = ien_q && !armed; // RL17

  always_comb begin
    csr_rdata = cmd_q & 8'h1f;
    csr_rdata[`FSPS_BIT_BUSY] = busy_q;
    csr_rdata[`FSPS_BIT_IEN] = ien_q;
  end

  // ==========================================================
  // temporary page buffer
  logic [15:0] buf_q [`FSPS_PAGE_WORDS];
  logic [`FSPS_PAGE_WORDS-1:0] bvalid_q;
  logic [6:0] slot;
  logic load_fire, buf_clr;
  assign slot = ptr.low[7:1] & 7'(`FSPS_PAGE_WORDS - 1);
  assign load_fire = fire && cmd_q == `FSPS_CMD_LOAD; // RL10
  assign buf_clr = op_done && op_q == fsps_pkg::FSPS_OP_PGWR ||
                   reen_wr; // RL12

  // eeprom activity never touches the buffer
  genvar gi;
  generate
    for (gi = 0; gi < `FSPS_PAGE_WORDS; gi++) begin : g_slot
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          bvalid_q[gi] <= 1'b0; // RL12 RL14
        else if (load_fire && slot == 7'(gi))
          bvalid_q[gi] <= 1'b1; // RL11
        else if (buf_clr)
          bvalid_q[gi] <= 1'b0;
      end
      always_ff @(posedge clk) begin
        if (load_fire && slot == 7'(gi))
          buf_q[gi] <= data_in; // RL11
      end
    end
  endgenerate

  // ==========================================================
  // array write port: streams buffer at end of page write
  logic [6:0] wr_idx_q;
  logic wr_act;
  assign wr_act = op_q == fsps_pkg::FSPS_OP_PGWR &&
                  cnt_q <= 32'(`FSPS_PAGE_WORDS) && cnt_q != 32'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      wr_idx_q <= 7'h0;
    else if (start_wr)
      wr_idx_q <= 7'h0;
    else if (wr_act)
      wr_idx_q <= wr_idx_q + 7'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_prog_we <= 1'b0;
      flash_wdata <= 16'h0;
      flash_word_idx <= 7'h0;
    end else begin
      flash_prog_we <= wr_act;
      flash_wdata <= bvalid_q[wr_idx_q] ? buf_q[wr_idx_q] : 16'hffff;
      flash_word_idx <= wr_idx_q;
    end
  end

  // ==========================================================
  // lock bits: program only, chip erase lives outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      lock_bits <= 8'hff;
    else if (start_lk)
      lock_bits <= lock_bits & (data_in.low | ~`FSPS_LOCK_MASK); // RL20 RL23
  end

  // ==========================================================
  // address paths
  assign prog_byte_addr = {ext_q, pointer_word}; // RL5
  // fuse is only read here; nothing in this block can write it
  assign reset_vector = boot_reset_select ? `FSPS_APP_RESET
                                          : BOOT_RESET; // RL1 RL2

  // ==========================================================
  // checks
  AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    op_done && ien_q |=> selfprog_irq) // RL17
    else $error("irq not raised at completion");
  sequence seq_armed_idle;
    $rose(armed) && !store_exec && !csr_we;
  endsequence
  sequence seq_no_store;
    (!store_exec && !csr_we) [*3];
  endsequence
  AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n)
    seq_armed_idle ##1 seq_no_store |=> !armed) // RL26
    else $error("arm bit not cleared after window");
  AST_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    prog_run |-> region_blocked) // RL18
    else $error("region not blocked during programming");
  AST_START_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    start_er || start_wr |=> busy_q && prog_run) // RL8 RL15
    else $error("erase or write did not start");
  AST_LOCK_NOHALT: assert property (@(posedge clk) disable iff (!rst_n)
    op_q == fsps_pkg::FSPS_OP_LOCK |-> !cpu_halt) // RL22
    else $error("cpu halted during lock programming");
  AST_EEP: assert property (@(posedge clk) disable iff (!rst_n)
    eeprom_busy && csr_we && !armed && !fire |=> !armed) // RL25
    else $error("command accepted during eeprom write");
  AST_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    op_done |=> !armed && op_q == fsps_pkg::FSPS_OP_NONE) // RL27
    else $error("arm bit not cleared at completion");
  AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    prog_run && !start_er && !start_wr |=> $stable(addr_q)) // RL4
    else $error("latched address moved");
  AST_VEC: assert property (@(posedge clk) disable iff (!rst_n)
    boot_reset_select |-> reset_vector == 24'h000000) // RL1
    else $error("wrong application reset vector");
  AST_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    buf_clr |=> bvalid_q == '0) // RL12
    else $error("buffer not cleared");
  AST_REEN: assert property (@(posedge clk) disable iff (!rst_n)
    reen_wr && !start_er && !start_wr |=> !region_blocked) // RL19
    else $error("busy flag not cleared by re-enable");
  AST_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    !buf_clr && !load_fire |=> $stable(bvalid_q)) // RL14
    else $error("buffer contents lost");
endmodule

/* File: include/fsps_regs.svh */
// command codes, field positions, reset values and timing for the sequencer
`ifndef FSPS_REGS_SVH
`define FSPS_REGS_SVH
`define FSPS_CSR_RST 8'h00
`define FSPS_EXT_RST 8'h00
`define FSPS_BIT_ARM 0
`define FSPS_BIT_ERASE 1
`define FSPS_BIT_PGWR 2
`define FSPS_BIT_LOCK 3
`define FSPS_BIT_REEN 4
`define FSPS_BIT_BUSY 6
`define FSPS_BIT_IEN 7
`define FSPS_CMD_MASK 8'h7f
`define FSPS_CMD_ERASE 8'h03
`define FSPS_CMD_LOAD 8'h01
`define FSPS_CMD_PGWR 8'h05
`define FSPS_CMD_LOCK 8'h09
`define FSPS_CMD_REEN 8'h11
`define FSPS_WINDOW 3'h4
`define FSPS_APP_RESET 24'h000000
`define FSPS_LOCK_MASK 8'h3f
`define FSPS_CLK_MHZ 125
`define FSPS_TMIN_US 3700
`define FSPS_TMAX_US 4500
`define FSPS_PROG_CYC ((`FSPS_TMIN_US + `FSPS_TMAX_US) / 2 * `FSPS_CLK_MHZ)
`define FSPS_PAGE_WORDS 128
`define FSPS_WORD_BITS 7
`endif

/* File: include/fsps_pkg.sv */
// types of the flash self-programming sequencer
package fsps_pkg;
  typedef enum logic [1:0] {
    FSPS_OP_NONE,
    FSPS_OP_ERASE,
    FSPS_OP_PGWR,
    FSPS_OP_LOCK
  } fsps_op_t;
  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } fsps_ptr_t;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } fsps_data_t;
endpackage

/* File: sim/fsps_cpu_model.sv */
// cpu-side model issuing command/store instruction pairs
`timescale 1ns/1ps
module fsps_cpu_model (
  input wire logic clk,
  output logic csr_we,
  output logic [7:0] csr_wdata,
  output logic store_exec,
  output fsps_pkg::fsps_ptr_t ptr,
  output fsps_pkg::fsps_data_t data_in
);
  // ==========================================
  // instruction pair
  initial begin
    csr_we = 1'b0;
    csr_wdata = 8'h00;
    store_exec = 1'b0;
    ptr = '0;
    data_in = '0;
  end
  // gap above 3 leaves the store window empty on purpose
  task automatic spm(input logic [7:0] code, input logic [23:0] p,
                     input logic [15:0] d, input int gap);
    @(negedge clk);
    csr_we = 1'b1;
    csr_wdata = code;
    ptr = p;
    data_in = d;
    @(negedge clk);
    csr_we = 1'b0;
    csr_wdata = ~code;
    repeat (gap) @(negedge clk);
    if (gap < 4) begin
      store_exec = 1'b1;
      @(negedge clk);
      store_exec = 1'b0;
    end
    // released data lines no longer show the old word
    data_in = ~d;
  endtask
endmodule

/* File: sim/fsps_seq_tb.sv */
// self-checking bench of the flash self-programming sequencer
`timescale 1ns/1ps
module fsps_seq_tb;
  localparam int PC = 200;
  logic clk, nrst, ext_we, boot_reset_select, eeprom_busy;
  logic [7:0] ext_wdata, csr_rdata, ext_rdata, lock_bits;
  logic [15:0] pointer_word, flash_wdata;
  logic [23:0] prog_byte_addr, reset_vector, flash_page_addr;
  logic cpu_halt, region_blocked, selfprog_irq, flash_prog_we;
  logic [6:0] flash_word_idx;
  logic csr_we, store_exec;
  logic [7:0] csr_wdata;
  fsps_pkg::fsps_ptr_t ptr;
  fsps_pkg::fsps_data_t data_in;
  logic [46:0] exp_q[$];
  logic [15:0] mem[128];
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  int slot;
  logic [46:0] strm;
  assign strm = {flash_page_addr, flash_word_idx, flash_wdata};
  // ==========================================
  // clock, partner, design
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  fsps_cpu_model cpu (.clk(clk), .csr_we(csr_we), .csr_wdata(csr_wdata),
    .store_exec(store_exec), .ptr(ptr), .data_in(data_in));
  fsps_seq #(.PROG_CYC(PC)) dut (.clk(clk), .nrst(nrst), .csr_we(csr_we),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .ext_we(ext_we),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .store_exec(store_exec), .ptr(ptr), .data_in(data_in),
    .pointer_word(pointer_word), .prog_byte_addr(prog_byte_addr),
    .boot_reset_select(boot_reset_select), .reset_vector(reset_vector),
    .eeprom_busy(eeprom_busy), .cpu_halt(cpu_halt),
    .region_blocked(region_blocked), .selfprog_irq(selfprog_irq),
    .lock_bits(lock_bits), .flash_prog_we(flash_prog_we),
    .flash_page_addr(flash_page_addr), .flash_wdata(flash_wdata),
    .flash_word_idx(flash_word_idx));
  task automatic chk(input string nm, input logic [46:0] e,
                     input logic [46:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded wait for the arm bit to drop
  task automatic wait_idle;
    n = 0;
    while (csr_rdata[0] !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 1000) begin
        bad_count++;
        give_verdict();
      end
    end
  endtask
  task automatic set_ext(input logic [7:0] v);
    @(negedge clk);
    ext_we = 1'b1;
    ext_wdata = v;
    @(negedge clk);
    ext_we = 1'b0;
  endtask
  task automatic page_op(input logic [7:0] c, input logic [23:0] pg,
                         input int gap, input logic halt);
    cpu.spm(c, pg, 16'hdead, gap);
    repeat (2) @(negedge clk);
    chk("halt", {46'h0, halt}, {46'h0, cpu_halt});
    chk("blocked", 47'h1, {46'h0, region_blocked});
    chk("irq", 47'h0, {46'h0, selfprog_irq});
  endtask
  // write stream results are noted in order and compared as they appear
  always @(negedge clk) begin
    if (flash_prog_we === 1'b1) begin
      if (exp_q.size() == 0) chk("stream", 47'h0, 47'h1);
      else chk("stream", exp_q.pop_front(), strm);
    end
  end
  initial begin
    nrst = 1'b0;
    ext_we = 1'b0;
    ext_wdata = 8'h00;
    pointer_word = 16'h0000;
    boot_reset_select = 1'b1;
    eeprom_busy = 1'b0;
    void'($urandom(93184));
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("vector", 47'h0, {23'h0, reset_vector});
    chk("locks", 47'hff, {39'h0, lock_bits});
    boot_reset_select = 1'b0;
    set_ext(8'h5a);
    pointer_word = 16'h1235;
    #1 chk("vector", 47'h03e000, {23'h0, reset_vector});
    chk("ext_rd", 47'h5a, {39'h0, ext_rdata});
    chk("byte_addr", 47'h5a1235, {23'h0, prog_byte_addr});
    foreach (mem[i]) mem[i] = 16'hffff;
    // scattered slots, each once; eeprom write in the middle
    for (int k = 0; k < 8; k++) begin
      slot = (k * 45 + 7) % 128;
      mem[slot] = 16'($urandom());
      cpu.spm(8'h01, {16'h0123, slot[6:0], 1'b0}, mem[slot], k % 4);
      if (k == 4) begin
        eeprom_busy = 1'b1;
        cpu.spm(8'h03, 24'h012300, 16'h0, 0);
        chk("refused", 47'h0, {46'h0, csr_rdata[0]});
        eeprom_busy = 1'b0;
      end
    end
    set_ext(8'h01);
    page_op(8'h83, 24'h012300, 1, 1'b0);
    wait_idle();
    chk("duration", 47'h1, {46'h0, n >= PC - 3 && n <= PC + 2});
    chk("irq", 47'h1, {46'h0, selfprog_irq});
    chk("busy", 47'h1, {46'h0, csr_rdata[6]});
    foreach (mem[i]) exp_q.push_back({24'h012300, i[6:0], mem[i]});
    page_op(8'h85, 24'h012300, 3, 1'b0);
    cpu.spm(8'h00, 24'h0777fe, 16'h0, 9);
    set_ext(8'h07);
    wait_idle();
    // last word shows on the edge where the arm bit drops
    @(negedge clk);
    chk("drained", 47'h0, {15'h0, exp_q.size()});
    cpu.spm(8'h01, 24'h03e106, 16'h1234, 0);
    cpu.spm(8'h91, 24'h0, 16'h0, 0);
    @(negedge clk);
    chk("busy", 47'h0, {46'h0, region_blocked});
    set_ext(8'h03);
    page_op(8'h83, 24'h03e100, 3, 1'b1);
    wait_idle();
    for (int i = 0; i < 128; i++)
      exp_q.push_back({24'h03e100, i[6:0], 16'hffff});
    page_op(8'h85, 24'h03e100, 0, 1'b1);
    wait_idle();
    cpu.spm(8'h91, 24'h0, 16'h0, 0);
    cpu.spm(8'h89, 24'h000001, 16'h00f2, 0);
    repeat (2) @(negedge clk);
    chk("lock_run", 47'h0, {45'h0, cpu_halt, region_blocked});
    wait_idle();
    chk("locks", 47'hf2, {39'h0, lock_bits});
    cpu.spm(8'h89, 24'h000001, 16'h00ff, 0);
    wait_idle();
    chk("locks", 47'hf2, {39'h0, lock_bits});
    cpu.spm(8'h83, 24'h012300, 16'h0, 9);
    chk("expired", 47'h0, {40'h0, region_blocked, csr_rdata[4:0]});
    chk("drained", 47'h0, {15'h0, exp_q.size()});
    give_verdict();
  end
endmodule
